/* verilog/ddcsc_defs.vh */
// ddcsc_defs.vh: constants of the ddc slave control block
// assumes: included by the ddc control design files only
`ifndef DDCSC_DEFS_VH
`define DDCSC_DEFS_VH

// special function register addresses
`define DDCSC_ADDR_WINDOW 8'hd4
`define DDCSC_ADDR_D1DATA 8'hd5
`define DDCSC_ADDR_PTR 8'hd6
`define DDCSC_ADDR_CTRL 8'hd7

// control register bit positions
`define DDCSC_B_SIZE 6
`define DDCSC_B_SWM 5
`define DDCSC_B_AMASK 4
`define DDCSC_B_LIRQ 3
`define DDCSC_B_LEN 2
`define DDCSC_B_MSIRQ 1
`define DDCSC_B_MODE 0

// reset values
`define DDCSC_RST_BYTE 8'h00
`define DDCSC_SHIFT_IDLE 9'h1ff

// data space page of the buffer
`define DDCSC_XPAGE 8'hff

// 7-bit slave address of the a0/a1 pair
`define DDCSC_SLAVE_ADDR 7'h50

// legacy link timing, in vertical sync clocks
`define DDCSC_INIT_CLKS 4'h9
`define DDCSC_BIT_LAST 4'h8
`define DDCSC_CNT_ONE 4'h1
`define DDCSC_CNT_ZERO 4'h0

`endif

/* verilog/ddcsc_ram.v */
// ddcsc_ram.v: 256 x 8 buffer memory of the ddc control block
// assumes: one writer per cycle, chosen by the control block
`timescale 1ns/1ps
module ddcsc_ram (
  // clock
  input wire clk,
  // access port
  input wire we,
  input wire [7:0] addr,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:255];

  // read is asynchronous so a fetch and its pointer step share one cycle
  assign rdata = mem[addr];

  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end
endmodule // ddcsc_ram

/* verilog/ddcsc_top.v */
// ddcsc_top.v: mode, arbitration and legacy link logic of the ddc slave unit
// assumes: mcu special function bus and data bus on clk; i2c engine outside on clk;
// vsync pin is asynchronous and is sampled here
`timescale 1ns/1ps
`include "ddcsc_defs.vh"
module ddcsc_top (
  // clock and reset
  input wire clk,
  input wire rstn,
  // special function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata_r,
  // data space port
  input wire [15:0] x_addr,
  input wire x_wr,
  input wire x_rd,
  input wire [7:0] x_wdata,
  output reg x_claim_r,
  output reg [7:0] x_rdata_r,
  // i2c engine side
  input wire i2c_enable,
  input wire i2c_addr_valid,
  input wire [6:0] i2c_addr,
  input wire i2c_tx_req,
  input wire i2c_rx_valid,
  input wire [7:0] i2c_rx_data,
  output reg i2c_addr_ack_r,
  output reg i2c_tx_valid_r,
  output reg [7:0] i2c_tx_data_r,
  output reg serial_byte_irq_r,
  // legacy link pins
  input wire vsync_in,
  output reg sda_o_r,
  output reg sda_oe_r,
  // interrupt requests
  output reg legacy_byte_irq_r,
  output reg mode_switch_irq_r
);
  localparam ST_OFF = 3'b001;
  localparam ST_INIT = 3'b010;
  localparam ST_SEND = 3'b100;

  // control register fields, buffer pointer and legacy data byte
  reg buffer_size_select_r;
  reg software_mode_select_r;
  reg address_mask_select_r;
  reg legacy_byte_irq_flag_r;
  reg legacy_mode_enable_r;
  reg mode_switch_irq_flag_r;
  reg mode_r;
  reg [7:0] buffer_address_pointer_r;
  reg [7:0] legacy_data_r;
  // legacy link state
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg [8:0] shift_r;
  reg vs_s1_r;
  reg vs_s2_r;
  reg vs_d_r;

  wire vclk_rise;
  wire unit_en;
  wire mcu_ok;
  wire engine_ok;
  wire win_rd;
  wire win_wr;
  wire x_hit;
  wire x_acc;
  wire addr_hit;
  wire legacy_load;
  wire auto_fetch;
  wire sw_byte;
  wire ctrl_wr;
  wire [7:0] ram_addr;
  wire [7:0] ram_rdata;
  wire [7:0] ptr_inc;
  wire [7:0] fetch_addr;
  wire ram_we;
  wire [6:0] slave_addr;

  reg [7:0] ptr_nxt;
  reg [2:0] state_nxt;
  reg [7:0] ctrl_view;

  assign unit_en = legacy_mode_enable_r | i2c_enable;
  assign mcu_ok = software_mode_select_r;
  assign engine_ok = unit_en & ~software_mode_select_r;
  assign win_rd = sfr_rd & (sfr_addr == `DDCSC_ADDR_WINDOW) & mcu_ok;
  assign win_wr = sfr_wr & (sfr_addr == `DDCSC_ADDR_WINDOW) & mcu_ok;
  // page is freed to external data only when disabled and not preloading
  assign x_hit = (x_addr[15:8] == `DDCSC_XPAGE) & (unit_en | software_mode_select_r);
  assign x_acc = x_hit & mcu_ok & (x_rd | x_wr) & ~(win_rd | win_wr);
  assign ctrl_wr = sfr_wr & (sfr_addr == `DDCSC_ADDR_CTRL);

  // slave address match, mask widens the match before and after the switch to ddc2b
  assign slave_addr = `DDCSC_SLAVE_ADDR;
  assign addr_hit = address_mask_select_r ?
    (i2c_addr[6:3] == slave_addr[6:3]) : (i2c_addr == slave_addr);

  // small buffer wraps the pointer within its own 128-byte half; fetches use the low half
  assign ptr_inc = buffer_size_select_r ? buffer_address_pointer_r + 8'h01 :
    {buffer_address_pointer_r[7], buffer_address_pointer_r[6:0] + 7'h01};
  assign fetch_addr = {buffer_size_select_r & buffer_address_pointer_r[7],
    buffer_address_pointer_r[6:0]};

  // vsync synchroniser, first stage only feeds the second
  always @(posedge clk) begin
    if (!rstn) begin
      vs_s1_r <= 1'b0;
      vs_s2_r <= 1'b0;
      vs_d_r <= 1'b0;
    end else begin
      vs_s1_r <= vsync_in;
      vs_s2_r <= vs_s1_r;
      vs_d_r <= vs_s2_r;
    end
  end
  assign vclk_rise = vs_s2_r & ~vs_d_r;

  // a byte boundary on the legacy link: 9th clock of init or of a byte
  assign legacy_load = vclk_rise & (((state_r == ST_INIT) & (cnt_r == `DDCSC_INIT_CLKS -
    `DDCSC_CNT_ONE)) | ((state_r == ST_SEND) & (cnt_r == `DDCSC_BIT_LAST)));
  assign auto_fetch = engine_ok & mode_r & i2c_tx_req;
  assign sw_byte = unit_en & software_mode_select_r & mode_r &
    (i2c_tx_req | i2c_rx_valid);

  // engine reads need no port of their own: in software mode it never touches memory
  assign ram_addr = (win_rd | win_wr) ? buffer_address_pointer_r :
    x_acc ? x_addr[7:0] : fetch_addr;
  assign ram_we = win_wr | (x_acc & x_wr);

  ddcsc_ram u_ram (
    .clk(clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(win_wr ? sfr_wdata : x_wdata),
    .rdata(ram_rdata)
  );

  // legacy link sequencer
  always @* begin
    state_nxt = state_r;
    if (!legacy_mode_enable_r || mode_r) begin
      state_nxt = ST_OFF;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_nxt = ST_INIT;
        end
        ST_INIT: begin
          if (legacy_load) begin
            state_nxt = ST_SEND;
          end
        end
        ST_SEND: begin
          state_nxt = ST_SEND;
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  // pointer: mcu write wins over any step in the same cycle
  always @* begin
    ptr_nxt = buffer_address_pointer_r;
    if (sfr_wr && sfr_addr == `DDCSC_ADDR_PTR) begin
      ptr_nxt = sfr_wdata;
    end else if (win_rd || win_wr) begin
      ptr_nxt = ptr_inc;
    end else if ((legacy_load && engine_ok) || auto_fetch) begin
      ptr_nxt = ptr_inc;
    end else if (engine_ok && mode_r && i2c_rx_valid) begin
      ptr_nxt = i2c_rx_data;
    end
  end

  always @* begin
    ctrl_view = `DDCSC_RST_BYTE;
    ctrl_view[`DDCSC_B_SIZE] = buffer_size_select_r;
    ctrl_view[`DDCSC_B_SWM] = software_mode_select_r;
    ctrl_view[`DDCSC_B_AMASK] = address_mask_select_r;
    ctrl_view[`DDCSC_B_LIRQ] = legacy_byte_irq_flag_r;
    ctrl_view[`DDCSC_B_LEN] = legacy_mode_enable_r;
    ctrl_view[`DDCSC_B_MSIRQ] = mode_switch_irq_flag_r;
    ctrl_view[`DDCSC_B_MODE] = mode_r;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      buffer_size_select_r <= 1'b0;
      software_mode_select_r <= 1'b0;
      address_mask_select_r <= 1'b0;
      legacy_byte_irq_flag_r <= 1'b0;
      legacy_mode_enable_r <= 1'b0;
      mode_switch_irq_flag_r <= 1'b0;
      mode_r <= 1'b0;
      buffer_address_pointer_r <= `DDCSC_RST_BYTE;
      legacy_data_r <= `DDCSC_RST_BYTE;
      state_r <= ST_OFF;
      cnt_r <= `DDCSC_CNT_ZERO;
      shift_r <= `DDCSC_SHIFT_IDLE;
      sfr_rdata_r <= `DDCSC_RST_BYTE;
      x_claim_r <= 1'b0;
      x_rdata_r <= `DDCSC_RST_BYTE;
      i2c_addr_ack_r <= 1'b0;
      i2c_tx_valid_r <= 1'b0;
      i2c_tx_data_r <= `DDCSC_RST_BYTE;
      serial_byte_irq_r <= 1'b0;
      sda_o_r <= 1'b0;
      sda_oe_r <= 1'b0;
      legacy_byte_irq_r <= 1'b0;
      mode_switch_irq_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        buffer_size_select_r <= sfr_wdata[`DDCSC_B_SIZE];
        software_mode_select_r <= sfr_wdata[`DDCSC_B_SWM];
        address_mask_select_r <= sfr_wdata[`DDCSC_B_AMASK];
        legacy_mode_enable_r <= sfr_wdata[`DDCSC_B_LEN];
      end
      if (sfr_wr && sfr_addr == `DDCSC_ADDR_D1DATA) begin
        legacy_data_r <= sfr_wdata;
      end
      // flags: hardware set beats a software clear in the same cycle
      legacy_byte_irq_flag_r <= (legacy_load & software_mode_select_r) |
        (legacy_byte_irq_flag_r & ~(ctrl_wr & ~sfr_wdata[`DDCSC_B_LIRQ]));
      mode_switch_irq_flag_r <= (unit_en & ~mode_r & i2c_enable & i2c_addr_valid & addr_hit) |
        (mode_switch_irq_flag_r & ~(ctrl_wr & ~sfr_wdata[`DDCSC_B_MSIRQ]));
      // ddc2b is left only by disabling the unit
      if (!unit_en) begin
        mode_r <= 1'b0;
      end else if (i2c_enable && i2c_addr_valid && addr_hit) begin
        mode_r <= 1'b1;
      end
      buffer_address_pointer_r <= ptr_nxt;
      state_r <= state_nxt;
      // the init to send step is a load edge, so only leaving or entering off clears
      if (state_r == ST_OFF || state_nxt == ST_OFF) begin
        cnt_r <= `DDCSC_CNT_ZERO;
        shift_r <= `DDCSC_SHIFT_IDLE;
      end else if (vclk_rise) begin
        if (legacy_load) begin
          cnt_r <= `DDCSC_CNT_ZERO;
          // msb first, 9th bit released as the null bit
          shift_r <= {(engine_ok ? ram_rdata : legacy_data_r), 1'b1};
        end else begin
          cnt_r <= cnt_r + `DDCSC_CNT_ONE;
          shift_r <= {shift_r[7:0], 1'b1};
        end
      end
      // init and null bit leave the line released
      sda_oe_r <= (state_r == ST_SEND) & ~shift_r[8];
      if (sfr_rd) begin
        case (sfr_addr)
          `DDCSC_ADDR_WINDOW: sfr_rdata_r <= mcu_ok ? ram_rdata : `DDCSC_RST_BYTE;
          `DDCSC_ADDR_D1DATA: sfr_rdata_r <= legacy_data_r;
          `DDCSC_ADDR_PTR: sfr_rdata_r <= buffer_address_pointer_r;
          `DDCSC_ADDR_CTRL: sfr_rdata_r <= ctrl_view;
          default: sfr_rdata_r <= `DDCSC_RST_BYTE;
        endcase
      end
      x_claim_r <= x_hit;
      if (x_rd) begin
        x_rdata_r <= x_acc ? ram_rdata : `DDCSC_RST_BYTE;
      end
      i2c_addr_ack_r <= i2c_enable & i2c_addr_valid & addr_hit;
      i2c_tx_valid_r <= auto_fetch;
      if (auto_fetch) begin
        i2c_tx_data_r <= ram_rdata;
      end
      serial_byte_irq_r <= sw_byte;
      legacy_byte_irq_r <= legacy_byte_irq_flag_r;
      mode_switch_irq_r <= mode_switch_irq_flag_r;
    end
  end
endmodule // ddcsc_top

/* verif/ddcsc_top_assertions.sv */
// ddcsc_top_assertions.sv: port checker of the ddc slave control unit
// assumes: bound to ddcsc_top, one clock, synchronous active low reset
`timescale 1ns/1ps
module ddcsc_top_assertions (
  // clock and reset
  input wire clk,
  input wire rstn,
  // inputs
  input wire sfr_rd,
  input wire i2c_enable,
  input wire i2c_addr_valid,
  input wire [6:0] i2c_addr,
  input wire i2c_tx_req,
  input wire i2c_rx_valid,
  input wire vsync_in,
  // outputs
  input wire [7:0] sfr_rdata_r,
  input wire i2c_addr_ack_r,
  input wire i2c_tx_valid_r,
  input wire serial_byte_irq_r,
  input wire sda_oe_r,
  input wire legacy_byte_irq_r,
  input wire mode_switch_irq_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // clocks since the vsync pin rose; saturates so an idle link never wraps
  reg vs_q_r;
  reg [3:0] vs_age_r;
  always @(posedge clk) begin
    vs_q_r <= vsync_in;
    if (!rstn) begin
      vs_age_r <= 4'hf;
    end else if (vsync_in && !vs_q_r) begin
      vs_age_r <= 4'h0;
    end else if (vs_age_r != 4'hf) begin
      vs_age_r <= vs_age_r + 4'h1;
    end
  end
  a_ack_on_match: assert property (
    $past(i2c_addr_valid && i2c_enable && i2c_addr == 7'h50) |-> i2c_addr_ack_r)
    else $error("address a0/a1 not acknowledged");
  a_ack_has_cause: assert property (
    i2c_addr_ack_r |-> $past(i2c_addr_valid && i2c_enable && i2c_addr[6:3] == 4'ha))
    else $error("acknowledge without a matching address");
  a_tx_has_req: assert property (
    i2c_tx_valid_r |-> $past(i2c_tx_req) && !serial_byte_irq_r)
    else $error("byte offered without a request");
  a_sw_irq_cause: assert property (
    serial_byte_irq_r |-> $past(i2c_tx_req || i2c_rx_valid))
    else $error("byte interrupt without a transfer");
  a_switch_on_ack: assert property (
    $rose(mode_switch_irq_r) |-> $past(i2c_addr_ack_r))
    else $error("switch interrupt without an address");
  a_byte_irq_vsync: assert property (
    $rose(legacy_byte_irq_r) |-> vs_age_r <= 4'h7)
    else $error("legacy byte interrupt away from vsync");
  a_drive_on_vsync: assert property (
    $rose(sda_oe_r) |-> vs_age_r <= 4'h7)
    else $error("data line driven away from vsync");
  a_rd_data_holds: assert property (
    !$past(sfr_rd) |-> $stable(sfr_rdata_r))
    else $error("read data moved without a read");
  c_ack: cover property (i2c_addr_ack_r);
  c_tx: cover property (i2c_tx_valid_r);
  c_lirq: cover property ($rose(legacy_byte_irq_r));
endmodule // ddcsc_top_assertions

bind ddcsc_top ddcsc_top_assertions i_ddcsc_top_assertions (.clk(clk), .rstn(rstn),
  .sfr_rd(sfr_rd), .i2c_enable(i2c_enable), .i2c_addr_valid(i2c_addr_valid),
  .i2c_addr(i2c_addr), .i2c_tx_req(i2c_tx_req), .i2c_rx_valid(i2c_rx_valid),
  .vsync_in(vsync_in), .sfr_rdata_r(sfr_rdata_r), .i2c_addr_ack_r(i2c_addr_ack_r),
  .i2c_tx_valid_r(i2c_tx_valid_r), .serial_byte_irq_r(serial_byte_irq_r),
  .sda_oe_r(sda_oe_r), .legacy_byte_irq_r(legacy_byte_irq_r),
  .mode_switch_irq_r(mode_switch_irq_r));

/* verif/ddcsc_host.sv */
// ddcsc_host.sv: pc host model, vsync clock and i2c engine events
// assumes: clk is the unit clock; the bench calls the tasks
`timescale 1ns/1ps
module ddcsc_host (
  // clock
  input wire clk,
  // toward the unit
  output logic vsync_in,
  output logic addr_valid,
  output logic [6:0] addr,
  output logic tx_req
);
  initial begin
    {vsync_in, addr_valid, tx_req} = 3'h0;
    addr = 7'h00;
  end
  // 800 ns per clock, odd offset keeps it off the unit clock phase
  task automatic vclk(input int n);
    repeat (n) begin
      #37 vsync_in = 1'b1;
      #400 vsync_in = 1'b0;
      #363;
    end
  endtask
  task automatic send_addr(input logic [6:0] a);
    @(posedge clk);
    #1 addr_valid = 1'b1;
    addr = a;
    @(posedge clk);
    #1 addr_valid = 1'b0;
    addr = ~a; // idle bus shows no stale address
  endtask
  task automatic pull_byte();
    @(posedge clk);
    #1 tx_req = 1'b1;
    @(posedge clk);
    #1 tx_req = 1'b0;
  endtask
endmodule // ddcsc_host

/* verif/ddc_slave_control_test.sv */
// ddc_slave_control_test.sv: self-checking bench of the ddc slave control unit
// assumes: ddcsc_host plays the pc host; this module plays the mcu
`timescale 1ns/1ps
module ddc_slave_control_test;
  logic clk, rstn, sfr_wr, sfr_rd, x_rd, i2c_en, ack, txv, sirq, sda_oe, lirq, msirq;
  logic [7:0] sfr_addr, sfr_wdata, rd, xd, txd, dat, mem [0:127];
  logic [7:0] xwd, rxd, sub;
  logic [15:0] x_addr;
  logic [6:0] a, ad;
  logic vs, av, txr, claim, x_wr, rxv, sda_o;
  int seed = 23;
  int mismatches = 0;
  int checks = 0;
  ddcsc_host i_ddcsc_host (.clk(clk), .vsync_in(vs), .addr_valid(av), .addr(ad), .tx_req(txr));
  ddcsc_top i_ddcsc_top (.clk(clk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_r(rd), .x_addr(x_addr), .x_wr(x_wr),
    .x_rd(x_rd), .x_wdata(xwd), .x_claim_r(claim), .x_rdata_r(xd), .i2c_enable(i2c_en),
    .i2c_addr_valid(av), .i2c_addr(ad), .i2c_tx_req(txr), .i2c_rx_valid(rxv),
    .i2c_rx_data(rxd), .i2c_addr_ack_r(ack), .i2c_tx_valid_r(txv), .i2c_tx_data_r(txd),
    .serial_byte_irq_r(sirq), .vsync_in(vs), .sda_o_r(sda_o), .sda_oe_r(sda_oe),
    .legacy_byte_irq_r(lirq), .mode_switch_irq_r(msirq));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic match(input logic [6:0] ad7, input logic m);
    return m ? (ad7[6:3] == 4'ha) : (ad7 == 7'h50);
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ra, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_wr = w;
    sfr_rd = ~w;
    sfr_addr = ra;
    sfr_wdata = d;
    @(posedge clk);
    #1 {sfr_wr, sfr_rd} = 2'b00;
  endtask
  task automatic xrd(input logic [7:0] xa);
    @(posedge clk);
    #1 x_rd = 1'b1;
    x_addr = {8'hff, xa};
    @(posedge clk);
    #1 x_rd = 1'b0;
    x_addr = 16'h0000;
  endtask
  task automatic xwr(input logic [7:0] xa, input logic [7:0] d);
    @(posedge clk);
    #1 x_wr = 1'b1;
    x_addr = {8'hff, xa};
    xwd = d;
    @(posedge clk);
    #1 x_wr = 1'b0;
    x_addr = 16'h0000;
  endtask
  task automatic rx(input logic [7:0] d);
    @(posedge clk);
    #1 rxv = 1'b1;
    rxd = d;
    @(posedge clk);
    #1 rxv = 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    mismatches++;
    test_done();
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, x_rd, x_wr, rxv, i2c_en} = 7'h00;
    {sfr_addr, sfr_wdata, x_addr, xwd, rxd} = 48'h0000_0000_0000;
    repeat (10) @(posedge clk);
    #1 rstn = 1'b1;
    bus(1'b0, 8'hd7, 8'h00);
    chk(rd, 8'h00);
    bus(1'b1, 8'hd7, 8'hff);
    bus(1'b0, 8'hd7, 8'h00);
    chk(rd, 8'h74);
    bus(1'b1, 8'hd7, 8'h20);
    i_ddcsc_host.vclk(9);
    chk({6'h00, lirq, sda_oe}, 8'h00);
    $display("test control done");
    // preload; 128 steps must wrap the small buffer pointer back to zero
    for (int i = 0; i < 128; i++) begin
      mem[i] = $random(seed);
      bus(1'b1, 8'hd4, mem[i]);
    end
    bus(1'b0, 8'hd6, 8'h00);
    chk(rd, 8'h00);
    bus(1'b0, 8'hd4, 8'h00);
    chk(rd, mem[0]);
    mem[32] = $random(seed);
    xwr(8'h20, mem[32]);
    xrd(8'h20);
    chk({claim, xd}, {1'b1, mem[32]});
    bus(1'b0, 8'hd6, 8'h00);
    chk(rd, 8'h01);
    xrd(8'h05);
    chk({claim, xd}, {1'b1, mem[5]});
    $display("test preload done");
    i2c_en = 1'b1;
    bus(1'b1, 8'hd7, 8'h00);
    bus(1'b1, 8'hd6, 8'h10);
    xrd(8'h05);
    chk({claim, xd}, {1'b1, 8'h00});
    xwr(8'h10, ~mem[16]);
    bus(1'b0, 8'hd4, 8'h00);
    chk(rd, 8'h00);
    i_ddcsc_host.send_addr(7'h50);
    chk({7'h00, ack}, 8'h01);
    bus(1'b0, 8'hd7, 8'h00);
    chk({rd, msirq}, {8'h03, 1'b1});
    for (int k = 0; k < 3; k++) begin
      i_ddcsc_host.pull_byte();
      chk({txv, txd}, {1'b1, mem[16+k]});
    end
    sub = $random(seed) & 8'h7f;
    rx(sub);
    i_ddcsc_host.pull_byte();
    chk({txv, txd}, {1'b1, mem[sub]});
    for (int m = 0; m < 2; m++) begin
      bus(1'b1, 8'hd7, m ? 8'h10 : 8'h00);
      for (int j = 0; j < 8; j++) begin
        a = (j == 0) ? 7'h57 : 7'h50 ^ ($random(seed) & 7'h0f);
        i_ddcsc_host.send_addr(a);
        chk({7'h00, ack}, {7'h00, match(a, m[0])});
      end
    end
    bus(1'b0, 8'hd7, 8'h00);
    chk(rd, 8'h11);
    bus(1'b1, 8'hd7, 8'h30);
    i_ddcsc_host.pull_byte();
    chk({6'h00, txv, sirq}, 8'h01);
    rx(~sub);
    chk({6'h00, txv, sirq}, 8'h01);
    bus(1'b0, 8'hd6, 8'h00);
    chk(rd, {1'b0, sub[6:0] + 7'h01});
    i2c_en = 1'b0;
    bus(1'b0, 8'hd7, 8'h00);
    chk(rd, 8'h30);
    bus(1'b1, 8'hd7, 8'h00);
    xrd(8'h05);
    chk({7'h00, claim}, 8'h00);
    $display("test serial done");
    dat = $random(seed);
    bus(1'b1, 8'hd5, dat);
    bus(1'b1, 8'hd7, 8'h24);
    i_ddcsc_host.vclk(9);
    chk({7'h00, lirq}, 8'h01);
    bus(1'b1, 8'hd7, 8'h24);
    @(posedge clk);
    #1;
    chk({7'h00, lirq}, 8'h00);
    for (int b = 7; b >= 0; b--) begin
      chk({7'h00, sda_oe}, {7'h00, ~dat[b]});
      i_ddcsc_host.vclk(1);
    end
    chk({6'h00, sda_o, sda_oe}, 8'h00);
    i_ddcsc_host.vclk(1);
    chk({6'h00, lirq, sda_oe}, {6'h00, 1'b1, ~dat[7]});
    bus(1'b1, 8'hd7, 8'h00);
    bus(1'b1, 8'hd6, 8'h03);
    bus(1'b1, 8'hd7, 8'h04);
    i_ddcsc_host.vclk(9);
    bus(1'b0, 8'hd6, 8'h00);
    chk(rd, 8'h04);
    chk({6'h00, lirq, sda_oe}, {6'h00, 1'b0, ~mem[3][7]});
    $display("test legacy done");
    test_done();
  end
endmodule // ddc_slave_control_test
